/* hdl/pmtr_consts.vh */
// constants for the program memory, table read and data memory map block
`ifndef PMTR_CONSTS_VH
`define PMTR_CONSTS_VH
`define PMTR_PC_W 12
`define PMTR_WORD_W 15
`define PMTR_DATA_W 8
`define PMTR_PROG_DEPTH 4096
`define PMTR_VEC_RESET 12'h000
`define PMTR_VEC_EXT 12'h004
`define PMTR_VEC_TMR0 12'h008
`define PMTR_VEC_TMR1 12'h00C
`define PMTR_VEC_BUS 12'h010
`define PMTR_VEC_SER1 12'h014
`define PMTR_VEC_SER2 12'h018
`define PMTR_LAST_PAGE 4'hF
`define PMTR_ADDR_IND_A 8'h00
`define PMTR_ADDR_PTR_A 8'h01
`define PMTR_ADDR_IND_B 8'h02
`define PMTR_ADDR_PTR_B 8'h03
`define PMTR_ADDR_TBL_LO 8'h07
`define PMTR_ADDR_TBL_HI_RES 8'h08
`define PMTR_ADDR_TBL_HI_PTR 8'h1F
`define PMTR_GP_BASE 8'h40
`define PMTR_ZERO8 8'h00
`define PMTR_OP_READ 3'h0
`define PMTR_OP_WRITE 3'h1
`define PMTR_OP_BITSET 3'h2
`define PMTR_OP_BITCLR 3'h3
`define PMTR_OP_TRC 3'h4
`define PMTR_OP_TRL 3'h5
`define PMTR_NUM_IRQ 6
`endif

/* hdl/pmtr_core.v */
// memory organisation: program store, vectors, table read and data memory map
`timescale 1ns/1ps
`include "pmtr_consts.vh"
// Functional notes
// - program store is 4K words of 15 bits, feeding fetch and tables
// - after reset fetch starts at program address zero
// - external interrupt taken with enable and stack room branches to 0x004
// - first timer overflow taken branches to 0x008
// - second timer overflow taken branches to 0x00C
// - bus-function interrupt taken branches to 0x010
// - first serial interface byte done branches to 0x014
// - option off: current-page read uses pc bits 11..8 and low pointer
// - option on: current-page read uses high pointer above low pointer
// - last-page read forces bits 11..8 high, reaching 0x0F00 to 0x0FFF
// - table read puts low byte to data location, rest into result high
// - table result high is read-only, changed only by table reads
// - both pointers read/write; high pointer ignored when option off
// - every table read takes two cycles
// - data memory is 256 bytes, general bytes 0x40 to 0xFF
// - unused addresses below 0x40 read as 0x00
// - every data location serves as operand for alu operations
// - every writable data bit can be set or cleared singly; result high at 0x08 drops it
// - indirect access through two pointers at 0x01 and 0x03
// - taking external interrupt clears its flag and global enable
// - stack full: request kept pending until a return frees a level
module pmtr_core #(
	parameter PC_W = `PMTR_PC_W,
	parameter WORD_W = `PMTR_WORD_W,
	parameter HIGH_PTR_OPT = 0
) (
	// clock and reset
	input wire clk,
	input wire rst,
	// program store loading
	input wire prog_wr_en,
	input wire [PC_W-1:0] prog_wr_addr,
	input wire [WORD_W-1:0] prog_wr_data,
	// fetch control from the core
	input wire fetch_en,
	input wire branch_en,
	input wire [PC_W-1:0] branch_addr,
	// interrupt requests, enables and stack state
	input wire [`PMTR_NUM_IRQ-1:0] irq_req,
	input wire [`PMTR_NUM_IRQ-1:0] irq_en,
	input wire global_enable_set,
	input wire ext_flag_clr,
	input wire stack_full,
	// data memory access
	input wire mem_req,
	input wire [2:0] mem_op,
	input wire [7:0] mem_addr,
	input wire [7:0] mem_wdata,
	input wire [2:0] mem_bit,
	// fetch outputs
	output reg [PC_W-1:0] pc,
	output reg [WORD_W-1:0] instr,
	output reg instr_valid,
	output reg irq_taken,
	output reg [PC_W-1:0] irq_vector,
	output reg global_interrupt_enable,
	output reg external_interrupt_request_flag,
	// data memory outputs
	output reg [7:0] mem_rdata,
	output reg mem_done,
	output reg mem_busy
);
	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	// physical resolution of an address, through pointers for 0x00/0x02
	function [7:0] pmtr_resolve;
		input [7:0] a;
		input [7:0] pa;
		input [7:0] pb;
		begin
			if (a == `PMTR_ADDR_IND_A) begin
				pmtr_resolve = pa;
			end else if (a == `PMTR_ADDR_IND_B) begin
				pmtr_resolve = pb;
			end else begin
				pmtr_resolve = a;
			end
		end
	endfunction

	// vector for an interrupt index
	function [11:0] pmtr_vec;
		input [2:0] idx;
		begin
			case (idx)
				3'h0: pmtr_vec = `PMTR_VEC_EXT;
				3'h1: pmtr_vec = `PMTR_VEC_TMR0;
				3'h2: pmtr_vec = `PMTR_VEC_TMR1;
				3'h3: pmtr_vec = `PMTR_VEC_BUS;
				3'h4: pmtr_vec = `PMTR_VEC_SER1;
				default: pmtr_vec = `PMTR_VEC_SER2;
			endcase
		end
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	localparam ST_IDLE = 2'b01;
	localparam ST_TBL = 2'b10;
	reg [1:0] state_reg;
	reg [7:0] ptr_a_reg;
	reg [7:0] ptr_b_reg;
	reg [7:0] tbl_lo_reg;
	reg [7:0] tbl_hi_ptr_reg;
	reg [7:0] tbl_res_hi_reg;
	reg [7:0] gp_ram [0:255];
	reg [7:0] tbl_dest_reg;
	reg [`PMTR_NUM_IRQ-1:0] pend_reg;
	reg fetch_d_reg;
	reg [PC_W-1:0] rd_addr;
	reg rd_en;
	reg [2:0] irq_idx;
	reg irq_any;
	wire [WORD_W-1:0] rd_data;
	wire [7:0] phys;
	wire tbl_take;
	reg [7:0] cur_val;
	reg [PC_W-1:0] tbl_addr;
	integer k;

	assign phys = pmtr_resolve(mem_addr, ptr_a_reg, ptr_b_reg);
	assign tbl_take = pmtr_is_tbl(state_reg == ST_IDLE, mem_req, mem_op);

	// ------------------------------------------------------------
	// program store
	// ------------------------------------------------------------
	pmtr_prog_mem #(.AW(PC_W), .DW(WORD_W)) u_prog (
		.clk(clk),
		.wr_en(prog_wr_en),
		.wr_addr(prog_wr_addr),
		.wr_data(prog_wr_data),
		.rd_en(rd_en),
		.rd_addr(rd_addr),
		.rd_data(rd_data)
	);

	// priority pick of pending, enabled requests; lowest vector wins
	always @* begin
		irq_any = 1'b0;
		irq_idx = 3'h0;
		for (k = `PMTR_NUM_IRQ-1; k >= 0; k = k - 1) begin
			if (pend_reg[k] && irq_en[k]) begin
				irq_any = 1'b1;
				irq_idx = k[2:0];
			end
		end
	end

	// table address forming; high pointer only matters with the option on
	always @* begin
		if (mem_op == `PMTR_OP_TRL) begin
			tbl_addr = {`PMTR_LAST_PAGE, tbl_lo_reg};
		end else if (HIGH_PTR_OPT != 0) begin
			tbl_addr = {tbl_hi_ptr_reg[3:0], tbl_lo_reg};
		end else begin
			tbl_addr = {pc[11:8], tbl_lo_reg};
		end
	end

	// read value of a physical data address; reserved space returns zero
	always @* begin
		if (phys >= `PMTR_GP_BASE) begin
			cur_val = gp_ram[phys];
		end else if (phys == `PMTR_ADDR_PTR_A) begin
			cur_val = ptr_a_reg;
		end else if (phys == `PMTR_ADDR_PTR_B) begin
			cur_val = ptr_b_reg;
		end else if (phys == `PMTR_ADDR_TBL_LO) begin
			cur_val = tbl_lo_reg;
		end else if (phys == `PMTR_ADDR_TBL_HI_RES) begin
			cur_val = tbl_res_hi_reg;
		end else if (phys == `PMTR_ADDR_TBL_HI_PTR) begin
			cur_val = tbl_hi_ptr_reg;
		end else begin
			cur_val = `PMTR_ZERO8;
		end
	end

	// memory read port mux: table read borrows the port for one cycle
	always @* begin
		rd_en = 1'b0;
		rd_addr = pc;
		if (tbl_take) begin
			rd_en = 1'b1;
			rd_addr = tbl_addr;
		end else if (fetch_en) begin
			rd_en = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// fetch, vectors and interrupt acknowledge
	// ------------------------------------------------------------
	// a request stays pending while the stack is full, so nothing is lost
	always @(posedge clk) begin
		if (rst) begin
			pc <= `PMTR_VEC_RESET;
			instr <= {WORD_W{1'b0}};
			instr_valid <= 1'b0;
			fetch_d_reg <= 1'b0;
			irq_taken <= 1'b0;
			irq_vector <= `PMTR_VEC_RESET;
			pend_reg <= {`PMTR_NUM_IRQ{1'b0}};
			global_interrupt_enable <= 1'b0;
			external_interrupt_request_flag <= 1'b0;
		end else begin
			fetch_d_reg <= fetch_en && !tbl_take;
			instr_valid <= fetch_d_reg;
			if (fetch_d_reg) begin
				instr <= rd_data;
			end
			irq_taken <= 1'b0;
			if (global_interrupt_enable && irq_any && !stack_full) begin
				pc <= pmtr_vec(irq_idx);
				irq_vector <= pmtr_vec(irq_idx);
				irq_taken <= 1'b1;
				global_interrupt_enable <= 1'b0;
				pend_reg <= (pend_reg & ~(6'h01 << irq_idx)) | irq_req;
			end else begin
				if (global_enable_set) begin
					global_interrupt_enable <= 1'b1;
				end
				// new events win over a software clear
				pend_reg <= (pend_reg & ~{5'h00, ext_flag_clr}) | irq_req;
				if (branch_en) begin
					pc <= branch_addr;
				end else if (fetch_en && !tbl_take) begin
					pc <= pc + 12'h001;
				end
			end
			external_interrupt_request_flag <= irq_req[0] |
				(pend_reg[0] & ~ext_flag_clr &
				~(global_interrupt_enable && irq_any && !stack_full && irq_idx == 3'h0));
		end
	end

	// true when this cycle's read port serves a table read
	function pmtr_is_tbl;
		input idle, req;
		input [2:0] op;
		begin
			pmtr_is_tbl = idle && req &&
				(op == `PMTR_OP_TRC || op == `PMTR_OP_TRL);
		end
	endfunction

	// ------------------------------------------------------------
	// data memory access and table read sequence
	// ------------------------------------------------------------
	// write-side effects of register writes; result high ignores writes
	always @(posedge clk) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			ptr_a_reg <= `PMTR_ZERO8;
			ptr_b_reg <= `PMTR_ZERO8;
			tbl_lo_reg <= `PMTR_ZERO8;
			tbl_hi_ptr_reg <= `PMTR_ZERO8;
			tbl_res_hi_reg <= `PMTR_ZERO8;
			tbl_dest_reg <= `PMTR_ZERO8;
			mem_rdata <= `PMTR_ZERO8;
			mem_done <= 1'b0;
			mem_busy <= 1'b0;
		end else begin
			mem_done <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (mem_req) begin
						case (mem_op)
							`PMTR_OP_READ: begin
								mem_rdata <= cur_val;
								mem_done <= 1'b1;
							end
							`PMTR_OP_WRITE: begin
								pmtr_store(phys, mem_wdata);
								mem_done <= 1'b1;
							end
							`PMTR_OP_BITSET: begin
								pmtr_store(phys, cur_val | (8'h01 << mem_bit));
								mem_done <= 1'b1;
							end
							`PMTR_OP_BITCLR: begin
								pmtr_store(phys, cur_val & ~(8'h01 << mem_bit));
								mem_done <= 1'b1;
							end
							`PMTR_OP_TRC, `PMTR_OP_TRL: begin
								tbl_dest_reg <= phys;
								mem_busy <= 1'b1;
								state_reg <= ST_TBL;
							end
							default: begin
								mem_done <= 1'b1;
							end
						endcase
					end
				end
				ST_TBL: begin
					pmtr_store(tbl_dest_reg, rd_data[7:0]);
					tbl_res_hi_reg <= {1'b0, rd_data[WORD_W-1:8]};
					mem_rdata <= rd_data[7:0];
					mem_done <= 1'b1;
					mem_busy <= 1'b0;
					state_reg <= ST_IDLE;
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// store to a physical address; reserved and read-only spaces drop it
	task pmtr_store;
		input [7:0] a;
		input [7:0] d;
		begin
			if (a >= `PMTR_GP_BASE) begin
				gp_ram[a] <= d;
			end else if (a == `PMTR_ADDR_PTR_A) begin
				ptr_a_reg <= d;
			end else if (a == `PMTR_ADDR_PTR_B) begin
				ptr_b_reg <= d;
			end else if (a == `PMTR_ADDR_TBL_LO) begin
				tbl_lo_reg <= d;
			end else if (a == `PMTR_ADDR_TBL_HI_PTR) begin
				tbl_hi_ptr_reg <= d;
			end
		end
	endtask
endmodule // pmtr_core

/* hdl/pmtr_prog_mem.v */
// program store: synchronous read, registered data, write port for loading
`timescale 1ns/1ps
`include "pmtr_consts.vh"
module pmtr_prog_mem #(
	parameter AW = `PMTR_PC_W,
	parameter DW = `PMTR_WORD_W
) (
	// clock
	input wire clk,
	// load port
	input wire wr_en,
	input wire [AW-1:0] wr_addr,
	input wire [DW-1:0] wr_data,
	// read port
	input wire rd_en,
	input wire [AW-1:0] rd_addr,
	output reg [DW-1:0] rd_data
);
	reg [DW-1:0] mem [0:(1<<AW)-1];

	// one write and one registered read per cycle
	always @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		if (rd_en) begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule // pmtr_prog_mem

/* tb/pmtr_core_model.sv */
// processor side model issuing data memory operations
`timescale 1ns/1ps
module pmtr_core_model (
	// clock
	input wire clk,
	// requests to the block
	output logic mem_req,
	output logic [2:0] mem_op,
	output logic [7:0] mem_addr,
	output logic [7:0] mem_wdata,
	output logic [2:0] mem_bit,
	// answers from the block
	input wire [7:0] mem_rdata,
	input wire mem_done
);
	initial begin
		mem_req = 1'b0;
		mem_op = 3'h0;
		mem_addr = 8'h00;
		mem_wdata = 8'h00;
		mem_bit = 3'h0;
	end
	// one operation; next one only after done, so table reads never overlap
	task automatic access(input logic [2:0] op, input logic [7:0] a, input logic [7:0] d,
		input logic [2:0] b, output logic [7:0] q);
		int n;
		@(negedge clk);
		mem_op = op;
		mem_addr = a;
		mem_wdata = d;
		mem_bit = b;
		mem_req = 1'b1;
		@(negedge clk);
		mem_req = 1'b0;
		// inverted lines so a stale value is never mistaken for a live one
		mem_addr = ~a;
		mem_wdata = ~d;
		n = 0;
		while (mem_done !== 1'b1 && n < 4) begin
			@(negedge clk);
			n++;
		end
		q = mem_rdata;
	endtask
endmodule // pmtr_core_model

/* tb/pmtr_core_sva.sv */
// port assertions for the memory map and table read block
`timescale 1ns/1ps
module pmtr_core_sva #(
	parameter PC_W = 12
) (
	// clock and reset
	input wire clk,
	input wire rst,
	// watched ports
	input wire mem_req,
	input wire [2:0] mem_op,
	input wire mem_busy,
	input wire mem_done,
	input wire [PC_W-1:0] pc,
	input wire irq_taken,
	input wire [PC_W-1:0] irq_vector,
	input wire global_interrupt_enable,
	input wire global_enable_set,
	input wire stack_full,
	input wire external_interrupt_request_flag
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// a request is taken only while no table read is in flight
	wire tk = mem_req && !mem_busy;
	sequence s_tbl;
		mem_busy ##1 (mem_done && !mem_busy);
	endsequence
	a_tbl_two_cycle: assert property (tk && mem_op[2] && !mem_op[1] |=> s_tbl)
		else $error("table read not done in two cycles");
	a_simple_one_cycle: assert property (tk && !(mem_op[2] && !mem_op[1])
		|=> mem_done && !mem_busy)
		else $error("data access not done in one cycle");
	a_busy_short: assert property (mem_busy |=> !mem_busy)
		else $error("busy longer than one cycle");
	a_done_has_cause: assert property (mem_done |-> $past(tk) || $past(mem_busy))
		else $error("done without a request");
	a_reset_start: assert property ($fell(rst) |-> pc == 0)
		else $error("fetch not at zero after reset");
	a_vector_table: assert property (irq_taken |-> pc == irq_vector
		&& irq_vector inside {12'h004, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h018})
		else $error("bad interrupt vector");
	a_irq_gie_drop: assert property (irq_taken |-> !global_interrupt_enable
		&& $past(global_interrupt_enable))
		else $error("global enable not dropped");
	a_stack_hold: assert property (stack_full |=> !irq_taken)
		else $error("interrupt taken with full stack");
	a_gie_gate: assert property (!global_interrupt_enable && !global_enable_set |=> !irq_taken)
		else $error("interrupt taken while disabled");
	a_ext_flag_clear: assert property (irq_taken && irq_vector == 12'h004
		|-> !external_interrupt_request_flag)
		else $error("external flag kept after entry");
endmodule // pmtr_core_sva
bind pmtr_core pmtr_core_sva #(.PC_W(PC_W)) pmtr_core_sva_inst (.clk, .rst, .mem_req, .mem_op,
	.mem_busy, .mem_done, .pc, .irq_taken, .irq_vector, .global_interrupt_enable,
	.global_enable_set, .stack_full, .external_interrupt_request_flag);

/* tb/test_pmtr_core.sv */
// self-checking bench for the memory map and table read block
`timescale 1ns/1ps
`include "pmtr_consts.vh"
module test_pmtr_core;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic prog_wr_en = 1'b0;
	logic [11:0] prog_wr_addr = 12'h000;
	logic [14:0] prog_wr_data = 15'h0000;
	logic fetch_en = 1'b0;
	logic [5:0] irq_req = 6'h00;
	logic [5:0] irq_en = 6'h3F;
	logic global_enable_set = 1'b0;
	logic ext_flag_clr = 1'b0;
	logic stack_full = 1'b0;
	wire mem_req, mem_done, mem_busy, instr_valid, irq_taken;
	wire global_interrupt_enable, external_interrupt_request_flag;
	wire [2:0] mem_op, mem_bit;
	wire [7:0] mem_addr, mem_wdata, mem_rdata;
	wire [11:0] pc, irq_vector;
	wire [14:0] instr;
	wire [7:0] hi_rdata;
	int errors = 0;
	int check_count = 0;
	logic [7:0] q;
	logic seen;
	always #5 clk = ~clk;
	pmtr_core pmtr_core_inst (.clk, .rst, .prog_wr_en, .prog_wr_addr, .prog_wr_data,
		.fetch_en, .branch_en(1'b0), .branch_addr(12'h000), .irq_req, .irq_en,
		.global_enable_set, .ext_flag_clr, .stack_full, .mem_req, .mem_op, .mem_addr,
		.mem_wdata, .mem_bit, .pc, .instr, .instr_valid, .irq_taken, .irq_vector,
		.global_interrupt_enable, .external_interrupt_request_flag, .mem_rdata,
		.mem_done, .mem_busy);
	// twin with the high pointer option on, fed the same inputs
	pmtr_core #(.HIGH_PTR_OPT(1)) pmtr_core_hi_inst (.clk, .rst, .prog_wr_en, .prog_wr_addr,
		.prog_wr_data, .fetch_en, .branch_en(1'b0), .branch_addr(12'h000), .irq_req, .irq_en,
		.global_enable_set, .ext_flag_clr, .stack_full, .mem_req, .mem_op, .mem_addr,
		.mem_wdata, .mem_bit, .pc(), .instr(), .instr_valid(), .irq_taken(), .irq_vector(),
		.global_interrupt_enable(), .external_interrupt_request_flag(), .mem_rdata(hi_rdata),
		.mem_done(), .mem_busy());
	pmtr_core_model pmtr_core_model_inst (.clk, .mem_req, .mem_op, .mem_addr, .mem_wdata,
		.mem_bit, .mem_rdata, .mem_done);
	// ----------------------------------------
	// shared helpers
	// ----------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic op(input logic [2:0] o, input logic [7:0] a, input logic [7:0] d,
		input logic [2:0] b);
		pmtr_core_model_inst.access(o, a, d, b, q);
		chk(mem_done, 1'b1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		pmtr_core_model_inst.access(`PMTR_OP_READ, a, 8'h00, 3'h0, q);
		chk(mem_done, 1'b1);
		chk(q, e);
	endtask
	task automatic prog(input logic [11:0] a, input logic [14:0] d);
		@(negedge clk);
		prog_wr_en = 1'b1;
		prog_wr_addr = a;
		prog_wr_data = d;
		@(negedge clk);
		prog_wr_en = 1'b0;
	endtask
	// the pulse is caught once; the vector and pc are judged on that cycle
	task automatic wait_irq(input int lim, input logic [11:0] v);
		seen = 1'b0;
		repeat (lim) begin
			@(negedge clk);
			if (irq_taken === 1'b1 && !seen) begin
				seen = 1'b1;
				chk(irq_vector, v);
				chk(pc, v);
			end
		end
	endtask
	task automatic set_gie;
		@(negedge clk);
		global_enable_set = 1'b1;
		@(negedge clk);
		global_enable_set = 1'b0;
	endtask
	task automatic pulse_irq(input int i);
		@(negedge clk);
		irq_req[i] = 1'b1;
		@(negedge clk);
		irq_req = 6'h00;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_fetch;
		chk(pc, 12'h000);
		prog(12'h000, 15'h2A55);
		@(negedge clk);
		fetch_en = 1'b1;
		@(negedge clk);
		fetch_en = 1'b0;
		repeat (4) if (instr_valid !== 1'b1) @(negedge clk);
		chk(instr_valid, 1'b1);
		chk(instr, 15'h2A55);
		chk(pc, 12'h001);
	endtask
	task automatic t_regs;
		logic [7:0] adr [4] = '{8'h01, 8'h03, 8'h07, 8'h1F};
		foreach (adr[i]) begin
			op(`PMTR_OP_WRITE, adr[i], 8'hA5 + i, 3'h0);
			rd(adr[i], 8'hA5 + i);
		end
		op(`PMTR_OP_WRITE, 8'h20, 8'h77, 3'h0);
		rd(8'h20, 8'h00);
		op(`PMTR_OP_WRITE, 8'h40, 8'h5A, 3'h0);
		op(`PMTR_OP_WRITE, 8'hFF, 8'hC3, 3'h0);
		rd(8'h40, 8'h5A);
		rd(8'hFF, 8'hC3);
		op(`PMTR_OP_WRITE, 8'h41, 8'h00, 3'h0);
		op(`PMTR_OP_BITSET, 8'h41, 8'h00, 3'h7);
		op(`PMTR_OP_BITSET, 8'h41, 8'h00, 3'h0);
		op(`PMTR_OP_BITCLR, 8'h41, 8'h00, 3'h7);
		rd(8'h41, 8'h01);
		op(`PMTR_OP_WRITE, 8'h01, 8'h50, 3'h0);
		op(`PMTR_OP_WRITE, 8'h00, 8'h3C, 3'h0);
		rd(8'h50, 8'h3C);
		op(`PMTR_OP_WRITE, 8'h03, 8'h51, 3'h0);
		op(`PMTR_OP_WRITE, 8'h02, 8'hE1, 3'h0);
		rd(8'h51, 8'hE1);
	endtask
	task automatic t_table;
		prog(12'hF12, 15'h7F3C);
		prog(12'h034, 15'h1234);
		prog(12'h534, 15'h0666);
		op(`PMTR_OP_WRITE, 8'h07, 8'h12, 3'h0);
		op(`PMTR_OP_TRL, 8'h60, 8'h00, 3'h0);
		rd(8'h60, 8'h3C);
		rd(8'h08, 8'h7F);
		op(`PMTR_OP_WRITE, 8'h08, 8'h80, 3'h0);
		rd(8'h08, 8'h7F);
		op(`PMTR_OP_WRITE, 8'h07, 8'h34, 3'h0);
		op(`PMTR_OP_WRITE, 8'h1F, 8'h05, 3'h0);
		op(`PMTR_OP_TRC, 8'h61, 8'h00, 3'h0);
		rd(8'h61, 8'h34);
		chk(hi_rdata, 8'h66);
		rd(8'h08, 8'h12);
		chk(hi_rdata, 8'h06);
	endtask
	task automatic t_irq;
		for (int i = 0; i < 6; i++) begin
			@(negedge clk);
			global_enable_set = 1'b1;
			@(negedge clk);
			global_enable_set = 1'b0;
			pulse_irq(i);
			wait_irq(4, 12'h004 + 12'(4 * i));
			chk(seen, 1'b1);
			chk(global_interrupt_enable, 1'b0);
		end
		stack_full = 1'b1;
		@(negedge clk);
		global_enable_set = 1'b1;
		@(negedge clk);
		global_enable_set = 1'b0;
		pulse_irq(0);
		wait_irq(5, 12'h004);
		chk(seen, 1'b0);
		chk(external_interrupt_request_flag, 1'b1);
		stack_full = 1'b0;
		wait_irq(4, 12'h004);
		chk(seen, 1'b1);
		chk(external_interrupt_request_flag, 1'b0);
		pulse_irq(0);
		chk(external_interrupt_request_flag, 1'b1);
		ext_flag_clr = 1'b1;
		@(negedge clk);
		ext_flag_clr = 1'b0;
		@(negedge clk);
		chk(external_interrupt_request_flag, 1'b0);
		// a masked source stays pending and is taken once enabled
		irq_en = 6'h3D;
		set_gie;
		pulse_irq(1);
		wait_irq(4, 12'h008);
		chk(seen, 1'b0);
		irq_en = 6'h3F;
		wait_irq(4, 12'h008);
		chk(seen, 1'b1);
		// an event in the same cycle as a clear must win
		irq_req[0] = 1'b1;
		ext_flag_clr = 1'b1;
		@(negedge clk);
		irq_req = 6'h00;
		ext_flag_clr = 1'b0;
		chk(external_interrupt_request_flag, 1'b1);
	endtask
	task automatic tally_and_finish;
		$display("checks=%0d errors=%0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (10) @(negedge clk);
		rst = 1'b0;
		t_fetch;
		t_regs;
		t_table;
		t_irq;
		tally_and_finish;
	end
	// the whole run needs under two thousand cycles
	initial begin
		#100000;
		errors++;
		tally_and_finish;
	end
endmodule // test_pmtr_core
